// [inc/arc_consts.vh]
`ifndef ARC_CONSTS_VH
`define ARC_CONSTS_VH

// =====================================================================
// register offsets
`define ARC_ADDR_W          16
`define ARC_OFF_STOP        16'h0001
`define ARC_OFF_MODE0       16'h0002
`define ARC_OFF_ACK_MODE    16'h0003
`define ARC_OFF_RX_HOLD     16'h0004
`define ARC_OFF_FAST_RX     16'h0005
`define ARC_OFF_EACK        16'h0006
`define ARC_OFF_STATE       16'h0080

// =====================================================================
// reset values
`define ARC_RST_ACK_MODE    8'hC0
`define ARC_RST_RX_HOLD     8'h00
`define ARC_RST_FAST_RX     8'h00
`define ARC_RST_EACK        8'h01
`define ARC_RST_MODE0       8'h00

// =====================================================================
// field positions
`define ARC_B_DETECT_POINT  7
`define ARC_B_SEQ_SUPPRESS  6
`define ARC_B_VER_BIT13     5
`define ARC_B_VER_BIT12     4
`define ARC_B_VER_SRC       3
`define ARC_B_AUTO_RX       4
`define ARC_MASK_ACK_MODE   8'hF8
`define ARC_MASK_BIT0       8'h01
`define ARC_MASK_MODE0      8'hFC

// =====================================================================
// timing: cycles spent in idle on the slow re-entry path
`define ARC_IDLE_CYCLES     2'h2

`endif

// [rtl/arc_ctrl.v]
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`include "arc_consts.vh"

// What this block does
// [RULE1] version select 0 copies received frame version, 1 uses programmed bits
// [RULE2] programmed bit 1 drives version bit 13, bit 0 drives bit 12
// [RULE3] suppress control inverted: 0 enables suppression, 1 disables it
// [RULE4] suppression omits reply sequence number when received frame had none
// [RULE5] ack detect at frame end when point bit 0, at header when 1
// [RULE6] ack reply mode register resets to C0H
// [RULE7] hold bit 1 in receive enters hold; clearing returns to receive
// [RULE8] host sets hold only in receive, never hold to transmit or assess
// [RULE9] host never asserts stop while in hold
// [RULE10] fast bit 0 re-enters receive via idle; 1 re-enters directly
// [RULE11] direct re-entry covers discards, level error, header error, cancel, auto rx
// [RULE12] enhanced ack enable is bit 0, resets to 01H
// [RULE13] stop halts tx, rx, assessment, calibration and goes idle
// [RULE14] auto receive mode 1 returns to receive after reception completes
// [RULE15] reserved bits read zero, writes to them ignored
module arc_ctrl (
  input  wire        i_sys_clk,
  input  wire        i_rst,
  input  wire        i_clk_en,
  input  wire [15:0] i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire        i_start_rx,
  input  wire        i_start_tx,
  input  wire        i_start_cca,
  input  wire        i_start_cal,
  input  wire        i_op_done,
  input  wire        i_rx_done,
  input  wire        i_rx_abort,
  input  wire        i_phr_rcvd,
  input  wire        i_frame_end,
  input  wire        i_ack_wait,
  input  wire [1:0]  i_rx_frame_ver,
  input  wire        i_rx_seq_present,
  output reg  [7:0]  o_rdata,
  output reg  [1:0]  o_reply_ver,
  output reg         o_reply_seq_present,
  output reg         o_ack_rcvd,
  output reg         o_eack_en,
  output reg         o_hold,
  output reg  [5:0]  o_state
);

  // =====================================================================
  // states
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_RX   = 6'h02;
  localparam [5:0] ST_HOLD = 6'h04;
  localparam [5:0] ST_TX   = 6'h08;
  localparam [5:0] ST_CCA  = 6'h10;
  localparam [5:0] ST_CAL  = 6'h20;

  // =====================================================================
  // registers
  reg  [7:0] ack_mode_r;
  reg  [7:0] hold_r;
  reg  [7:0] fast_r;
  reg  [7:0] eack_r;
  reg  [7:0] mode0_r;
  reg  [5:0] state_r;
  reg  [5:0] state_nxt;
  reg  [1:0] idle_cnt_r;
  reg        reenter_r;
  reg  [1:0] ver_ff_r;
  reg        seq_ff_r;
  wire [1:0] fmt_ver;
  wire       fmt_seq;
  wire       stop_wr;

  function hit;
    input [15:0] a;
    input [15:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  assign stop_wr = i_wr & hit(i_addr, `ARC_OFF_STOP) & i_wdata[0];

  // =====================================================================
  // register writes
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_mode_r <= `ARC_RST_ACK_MODE; // [RULE6]
      hold_r     <= `ARC_RST_RX_HOLD;
      fast_r     <= `ARC_RST_FAST_RX;
      eack_r     <= `ARC_RST_EACK; // [RULE12]
      mode0_r    <= `ARC_RST_MODE0;
    end else if (i_clk_en) begin
      if (i_wr) begin
        if (hit(i_addr, `ARC_OFF_ACK_MODE))
          ack_mode_r <= i_wdata & `ARC_MASK_ACK_MODE; // [RULE15]
        if (hit(i_addr, `ARC_OFF_RX_HOLD))
          hold_r <= i_wdata & `ARC_MASK_BIT0; // [RULE15]
        if (hit(i_addr, `ARC_OFF_FAST_RX))
          fast_r <= i_wdata & `ARC_MASK_BIT0;
        if (hit(i_addr, `ARC_OFF_EACK))
          eack_r <= i_wdata & `ARC_MASK_BIT0;
        if (hit(i_addr, `ARC_OFF_MODE0))
          mode0_r <= i_wdata & `ARC_MASK_MODE0;
      end
    end
  end

  // =====================================================================
  // read port: data one cycle after the strobe, unmapped reads zero
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_clk_en) begin
      o_rdata <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          `ARC_OFF_MODE0:    o_rdata <= mode0_r;
          `ARC_OFF_ACK_MODE: o_rdata <= ack_mode_r;
          `ARC_OFF_RX_HOLD:  o_rdata <= hold_r;
          `ARC_OFF_FAST_RX:  o_rdata <= fast_r;
          `ARC_OFF_EACK:     o_rdata <= eack_r;
          `ARC_OFF_STATE:    o_rdata <= {2'h0, state_r};
          default:           o_rdata <= 8'h00; // stop register always reads 0
        endcase
      end
    end
  end

  // =====================================================================
  // receive-state machine
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (reenter_r && idle_cnt_r == 2'h0)
          state_nxt = ST_RX; // [RULE10]
        else if (i_start_rx)
          state_nxt = ST_RX;
        else if (i_start_tx)
          state_nxt = ST_TX;
        else if (i_start_cca)
          state_nxt = ST_CCA;
        else if (i_start_cal)
          state_nxt = ST_CAL;
      end
      ST_RX: begin
        if (hold_r[0])
          state_nxt = ST_HOLD; // [RULE7]
        else if (i_rx_abort || (i_rx_done && mode0_r[`ARC_B_AUTO_RX]))
          state_nxt = fast_r[0] ? ST_RX : ST_IDLE; // [RULE10] [RULE11] [RULE14]
        else if (i_rx_done)
          state_nxt = ST_IDLE;
        else if (i_start_tx)
          state_nxt = ST_TX;
        else if (i_start_cca)
          state_nxt = ST_CCA;
      end
      // host keeps tx/assess requests away from hold, so none are honoured here
      ST_HOLD: begin
        if (!hold_r[0])
          state_nxt = ST_RX; // [RULE7] [RULE8]
      end
      ST_TX, ST_CCA, ST_CAL: begin
        if (i_op_done)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (stop_wr && state_r != ST_HOLD)
      state_nxt = ST_IDLE; // [RULE13] [RULE9]
  end

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r    <= ST_IDLE;
      idle_cnt_r <= 2'h0;
      reenter_r  <= 1'b0;
    end else if (i_clk_en) begin
      state_r <= state_nxt;
      if (stop_wr) begin
        reenter_r <= 1'b0; // stop cancels automatic re-entry
      end else if (state_r == ST_RX && state_nxt == ST_IDLE &&
                   (i_rx_abort || (i_rx_done && mode0_r[`ARC_B_AUTO_RX]))) begin
        reenter_r  <= 1'b1; // [RULE10] [RULE14]
        idle_cnt_r <= `ARC_IDLE_CYCLES - 2'h1;
      end else if (state_r == ST_IDLE && reenter_r) begin
        if (idle_cnt_r == 2'h0)
          reenter_r <= 1'b0;
        else
          idle_cnt_r <= idle_cnt_r - 2'h1;
      end
    end
  end

  // =====================================================================
  // reply formatting and ack detection
  arc_reply_fmt u_fmt (
    .i_ver_src_sel       (ack_mode_r[`ARC_B_VER_SRC]),
    .i_ver_prog          ({ack_mode_r[`ARC_B_VER_BIT13], ack_mode_r[`ARC_B_VER_BIT12]}),
    .i_rx_frame_ver      (ver_ff_r),
    .i_seq_suppress_n    (ack_mode_r[`ARC_B_SEQ_SUPPRESS]),
    .i_rx_seq_present    (seq_ff_r),
    .o_reply_ver         (fmt_ver),
    .o_reply_seq_present (fmt_seq)
  );

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ver_ff_r            <= 2'h0;
      seq_ff_r            <= 1'b0;
      o_reply_ver         <= 2'h0;
      o_reply_seq_present <= 1'b0;
      o_ack_rcvd          <= 1'b0;
      o_eack_en           <= 1'b0;
      o_hold              <= 1'b0;
      o_state             <= ST_IDLE;
    end else if (i_clk_en) begin
      ver_ff_r            <= i_rx_frame_ver;
      seq_ff_r            <= i_rx_seq_present;
      o_reply_ver         <= fmt_ver; // [RULE1] [RULE2]
      o_reply_seq_present <= fmt_seq; // [RULE4]
      // ack seen on header or on frame end as the point bit selects
      o_ack_rcvd <= i_ack_wait & (ack_mode_r[`ARC_B_DETECT_POINT] ? i_phr_rcvd
                                                                 : i_frame_end); // [RULE5]
      o_eack_en  <= eack_r[0]; // [RULE12]
      o_hold     <= (state_nxt == ST_HOLD);
      o_state    <= state_nxt;
    end
  end

endmodule

// [rtl/arc_reply_fmt.v]
`timescale 1ns/10ps
// =====================================================================
// reply header builder: frame version and sequence number presence
module arc_reply_fmt (
  input  wire       i_ver_src_sel,
  input  wire [1:0] i_ver_prog,
  input  wire [1:0] i_rx_frame_ver,
  input  wire       i_seq_suppress_n,
  input  wire       i_rx_seq_present,
  output wire [1:0] o_reply_ver,
  output wire       o_reply_seq_present
);

  // bit 1 of the version is frame bit 13, bit 0 is frame bit 12
  assign o_reply_ver = i_ver_src_sel ? i_ver_prog : i_rx_frame_ver; // [RULE1] [RULE2]
  // suppress control is active low: 0 means leave the field out when the received frame had none
  assign o_reply_seq_present = i_seq_suppress_n | i_rx_seq_present; // [RULE3] [RULE4]

endmodule

// [testbench/arc_ctrl_chk.sv]
`timescale 1ns/10ps
// ==========
// port timing of the control block
module arc_chk (
  input wire        i_sys_clk,
  input wire        i_rst,
  input wire [15:0] i_addr,
  input wire [7:0]  i_wdata,
  input wire        i_wr,
  input wire        i_rx_abort,
  input wire        i_phr_rcvd,
  input wire        i_frame_end,
  input wire        i_ack_wait,
  input wire [1:0]  i_rx_frame_ver,
  input wire        i_rx_seq_present,
  input wire [1:0]  o_reply_ver,
  input wire        o_reply_seq_present,
  input wire        o_ack_rcvd,
  input wire        o_hold,
  input wire [5:0]  o_state
);
  logic [7:0] mode_r;
  logic       fast_r;
  logic [1:0] up_r;
  // mode shadows; up_r skips the reply pipe fill after reset
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_r <= 8'hC0;
      fast_r <= 1'b0;
      up_r   <= 2'h0;
    end else begin
      up_r <= {up_r[0], 1'b1};
      if (i_wr && i_addr == 16'h0003) mode_r <= i_wdata & 8'hF8;
      if (i_wr && i_addr == 16'h0005) fast_r <= i_wdata[0];
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  chk_ver_source: assert property (up_r[1] |->
    o_reply_ver == ($past(mode_r[3]) ? $past(mode_r[5:4]) : $past(i_rx_frame_ver, 2)))
    else $error("reply version wrong");
  chk_seq_suppress: assert property (up_r[1] |->
    o_reply_seq_present == ($past(mode_r[6]) | $past(i_rx_seq_present, 2)))
    else $error("reply sequence presence wrong");
  chk_ack_header: assert property (i_ack_wait && mode_r[7] && i_phr_rcvd |=> o_ack_rcvd)
    else $error("ack missed at header");
  chk_ack_end: assert property (i_ack_wait && !mode_r[7] && i_frame_end |=> o_ack_rcvd)
    else $error("ack missed at frame end");
  chk_ack_cause: assert property (o_ack_rcvd |->
    $past(i_ack_wait && (mode_r[7] ? i_phr_rcvd : i_frame_end))) else $error("ack without cause");
  chk_hold_enter: assert property (o_state == 6'h02 && i_wr && i_addr == 16'h0004 &&
    i_wdata[0] |=> ##1 o_hold && o_state == 6'h04) else $error("hold not entered");
  chk_hold_exit: assert property ($past(o_state) == 6'h04 |-> !o_state[3] && !o_state[4])
    else $error("hold left to tx or cca");
  chk_fast_direct: assert property (o_state == 6'h02 && i_rx_abort && fast_r |=>
    o_state == 6'h02) else $error("fast re-entry left rx");
  chk_slow_idle: assert property (o_state == 6'h02 && i_rx_abort && !fast_r |=>
    o_state == 6'h01 [*2] ##1 o_state == 6'h02) else $error("slow re-entry wrong");
  chk_stop_idle: assert property ($past(i_wr && i_addr == 16'h0001 && i_wdata[0]) &&
    !$past(o_hold) |-> ##[0:1] o_state == 6'h01) else $error("stop did not idle");
  cover property (o_hold);
  cover property (o_ack_rcvd);
  cover property (o_state == 6'h20);
endmodule

bind arc_ctrl arc_chk i_arc_chk (.*);

// [testbench/arc_ctrl_tb.sv]
`timescale 1ns/10ps
// ==========
// scenario bench
module arc_ctrl_tb;
  logic        clk, rst, wr, rd, aw, sq, sqo, ack, eack, hold;
  logic [15:0] addr;
  logic [7:0]  wd, rdat, rv;
  logic [8:0]  ev;
  logic [1:0]  ver, vero;
  logic [5:0]  st;
  int          fails, cmp_count;
  arc_host i_arc_host (.i_sys_clk(clk), .i_rdata(rdat), .o_addr(addr), .o_wdata(wd),
    .o_wr(wr), .o_rd(rd));
  arc_ctrl i_arc_ctrl (.i_sys_clk(clk), .i_rst(rst), .i_clk_en(1'b1), .i_addr(addr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .i_start_rx(ev[0]), .i_start_tx(ev[1]),
    .i_start_cca(ev[2]), .i_start_cal(ev[3]), .i_op_done(ev[4]), .i_rx_done(ev[5]),
    .i_rx_abort(ev[6]), .i_phr_rcvd(ev[7]), .i_frame_end(ev[8]), .i_ack_wait(aw),
    .i_rx_frame_ver(ver), .i_rx_seq_present(sq), .o_rdata(rdat), .o_reply_ver(vero),
    .o_reply_seq_present(sqo), .o_ack_rcvd(ack), .o_eack_en(eack), .o_hold(hold), .o_state(st));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    i_arc_host.rd(a, rv);
    chk(rv, e);
  endtask
  task automatic go(input int b, input logic [5:0] e);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
    @(negedge clk);
    chk({2'h0, st}, {2'h0, e});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_regs();
    rc(16'h0003, 8'hC0);
    rc(16'h0006, 8'h01);
    chk({7'h0, eack}, 8'h01);
    rc(16'h0004, 8'h00);
    rc(16'h0005, 8'h00);
    rc(16'h0100, 8'h00);
    i_arc_host.wr(16'h0003, 8'hFF);
    rc(16'h0003, 8'hF8);
    for (int a = 4; a < 7; a++) begin
      i_arc_host.wr(a[15:0], 8'hFE);
      rc(a[15:0], 8'h00);
    end
    i_arc_host.wr(16'h0006, 8'h01);
  endtask
  task automatic t_reply();
    for (int m = 0; m < 8; m++) begin
      @(posedge clk);
      ver <= ~m[1:0];
      sq <= m[0];
      i_arc_host.wr(16'h0003, {1'b1, m[1], m[1:0], m[2], 3'h0});
      wt(3);
      chk({6'h0, vero}, {6'h0, m[2] ? m[1:0] : ~m[1:0]});
      chk({7'h0, sqo}, {7'h0, m[1] | m[0]});
    end
    for (int p = 0; p < 2; p++) begin
      i_arc_host.wr(16'h0003, {p[0], 7'h40});
      aw <= 1'b1;
      go(7, 6'h01);
      chk({7'h0, ack}, p[7:0]);
      go(8, 6'h01);
      chk({7'h0, ack}, {7'h0, !p[0]});
      @(posedge clk);
      aw <= 1'b0;
    end
  endtask
  task automatic t_states();
    go(0, 6'h02);
    i_arc_host.wr(16'h0004, 8'h01);
    wt(1);
    chk({2'h0, st}, 8'h04);
    chk({7'h0, hold}, 8'h01);
    i_arc_host.wr(16'h0004, 8'h00);
    wt(1);
    chk({2'h0, st}, 8'h02);
    go(6, 6'h01);
    wt(2);
    chk({2'h0, st}, 8'h02);
    i_arc_host.wr(16'h0005, 8'h01);
    go(6, 6'h02);
    i_arc_host.wr(16'h0002, 8'h10);
    go(5, 6'h02);
    i_arc_host.wr(16'h0005, 8'h00);
    go(5, 6'h01);
    wt(2);
    chk({2'h0, st}, 8'h02);
    i_arc_host.wr(16'h0002, 8'h00);
    go(5, 6'h01);
    go(0, 6'h02);
    go(1, 6'h08);
    i_arc_host.wr(16'h0001, 8'h01);
    wt(1);
    chk({2'h0, st}, 8'h01);
    go(3, 6'h20);
    go(4, 6'h01);
    go(2, 6'h10);
    i_arc_host.wr(16'h0001, 8'h01);
    wt(1);
    chk({2'h0, st}, 8'h01);
  endtask
  task automatic complete_run();
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    ev = 9'h000;
    aw = 1'b0;
    sq = 1'b0;
    ver = 2'h0;
    fails = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_reply();
    t_states();
    complete_run();
  end
endmodule

// [testbench/arc_host.sv]
`timescale 1ns/10ps
// ==========
// host: register bus master, one-cycle strobes
module arc_host (
  input  wire         i_sys_clk,
  input  wire  [7:0]  i_rdata,
  output logic [15:0] o_addr = 16'h0000,
  output logic [7:0]  o_wdata = 8'h00,
  output logic        o_wr = 1'b0,
  output logic        o_rd = 1'b0
);
  // callers set hold only in rx and never stop while in hold
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_sys_clk);
    o_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_sys_clk);
    o_rd   <= 1'b0;
    @(negedge i_sys_clk);
    d = i_rdata;
  endtask
endmodule
